// >>> wsd_pkg.sv
// Package holding register map, field layout and encodings of the waveform steer/shutdown block
package wsd_pkg;

  // Register bus geometry
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;

  // Register offsets
  localparam logic [2:0] OFS_STEER = 3'h0;
  localparam logic [2:0] OFS_SD_CTRL = 3'h1;
  localparam logic [2:0] OFS_SRC_EN = 3'h2;
  localparam logic [2:0] OFS_RISE_DB = 3'h3;
  localparam logic [2:0] OFS_GEN_CTRL = 3'h4;
  localparam logic [2:0] OFS_POLARITY = 3'h5;

  // Steering register fields
  localparam int STEER_EN_LSB = 0;
  localparam int STEER_OVR_LSB = 4;

  // Shutdown control register fields
  localparam int SD_STATUS_BIT = 7;
  localparam int SD_RESTART_BIT = 6;
  localparam int SD_BD_LSB = 4;
  localparam int SD_AC_LSB = 2;

  // Generator control register fields
  localparam int GEN_ENABLE_BIT = 7;
  localparam int GEN_MODE_LSB = 0;

  // Widths
  localparam int NUM_OUT = 4;
  localparam int SRC_W = 5;
  localparam int DB_W = 6;
  localparam int MODE_W = 3;

  // Reset values
  localparam logic [7:0] RST_STEER = 8'h00;
  localparam logic [7:0] RST_SD_CTRL = 8'h14;
  localparam logic [7:0] RST_SRC_EN = 8'h00;
  localparam logic [7:0] RST_RISE_DB = 8'h00;
  localparam logic [7:0] RST_GEN_CTRL = 8'h00;
  localparam logic [7:0] RST_POLARITY = 8'h00;

  // Mode codes
  localparam logic [2:0] MODE_STEER_ASYNC = 3'h0;
  localparam logic [2:0] MODE_STEER_SYNC = 3'h1;

  // Shutdown drive codes for an output pair
  typedef enum logic [1:0] {
    DRV_INACTIVE = 2'h0,
    DRV_FLOAT = 2'h1,
    DRV_LOW = 2'h2,
    DRV_HIGH = 2'h3
  } wsd_drive_t;

  // Shutdown sequencing states
  typedef enum logic [2:0] {
    ST_RUN = 3'b001,
    ST_SHUT = 3'b010,
    ST_WAIT_RISE = 3'b100
  } wsd_state_t;

endpackage

// >>> wsd_rise_delay.sv
// Rising-edge dead-band delay for the generator data waveform
`timescale 1ns/10ps
module wsd_rise_delay
  import wsd_pkg::*;
#(
  parameter int CNT_W = DB_W
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic din,
  input wire logic [CNT_W-1:0] count,
  output logic dout
);

  logic din_prev;
  logic [CNT_W-1:0] remain;
  logic pending;

  // Previous sample for edge detection
  always_ff @(posedge clk) begin
    if (!rstn) begin
      din_prev <= 1'b0;
    end else begin
      din_prev <= din;
    end
  end

  // Count down after a rising edge; a falling edge aborts at once
  always_ff @(posedge clk) begin
    if (!rstn) begin
      remain <= '0;
      pending <= 1'b0;
      dout <= 1'b0;
    end else if (count == '0) begin
      pending <= 1'b0;
      remain <= '0;
      dout <= din;
    end else if (!din) begin
      pending <= 1'b0;
      remain <= '0;
      dout <= 1'b0;
    end else if (!din_prev) begin
      pending <= 1'b1;
      remain <= count - 1'b1;
      dout <= 1'b0;
    end else if (pending) begin
      if (remain == '0) begin
        pending <= 1'b0;
        dout <= 1'b1;
      end else begin
        remain <= remain - 1'b1;
      end
    end
  end

endmodule

// >>> wsd_top.sv
// Output steering, auto-shutdown and rising dead-band logic of the waveform generator
//
// Contract
// - steering set: output is data waveform with polarity
// - steering clear: output takes its override bit
// - steering bits apply only in modes 00x
// - shutdown status bit 7 shows shutdown state
// - software writes status while disabled, forcing shutdown
// - after clear, hold shutdown until data rises
// - auto-restart enable lives in bit 6
// - bits 5-4 choose B/D shutdown drive
// - bits 3-2 choose A/C shutdown drive
// - code 00 drives inactive level after dead-band
// - shutdown control resets to 0x14, float codes
// - five source enables: pin, comp1, comp2, cells
// - rise dead-band delays N to N+1 periods
// - rise count zero bypasses the dead-band
// - unused register bits read as zero
// - auto-restart clears status when shutdown ends
// - polarity bit set inverts its output
// - mode 000 async steering, 001 sync steering
//
// The implementer's own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/10ps
module wsd_top
  import wsd_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [DATA_W-1:0] reg_rdata,
  input wire logic data_in,
  input wire logic shutdown_pin_input,
  input wire logic shutdown_comp1,
  input wire logic shutdown_comp2,
  input wire logic shutdown_cell2,
  input wire logic shutdown_cell4,
  output logic wave_out_a,
  output logic wave_out_b,
  output logic wave_out_c,
  output logic wave_out_d,
  output logic wave_oe_a,
  output logic wave_oe_b,
  output logic wave_oe_c,
  output logic wave_oe_d
);

  // Software visible fields
  logic [NUM_OUT-1:0] steer_enable;
  logic [NUM_OUT-1:0] override_level;
  logic shutdown_status;
  logic restart_enable;
  logic [1:0] shutdown_drive_pair_bd;
  logic [1:0] shutdown_drive_pair_ac;
  logic [SRC_W-1:0] shutdown_src_enable;
  logic [DB_W-1:0] rise_deadband_value;
  logic gen_enable;
  logic [MODE_W-1:0] gen_mode;
  logic [NUM_OUT-1:0] invert_out;

  // Internal state
  wsd_state_t state;
  wsd_state_t next_state;
  logic data_prev;
  logic data_rise;
  logic src_active;
  logic steering_mode;
  logic [NUM_OUT-1:0] steer_live;
  logic [DB_W-1:0] sd_wait;
  logic wave_delayed;
  logic [NUM_OUT-1:0] out_q;
  logic [NUM_OUT-1:0] oe_q;
  logic [NUM_OUT-1:0] next_out;
  logic [NUM_OUT-1:0] next_oe;
  logic wr_sd;
  logic [NUM_OUT-1:0] steer_sel;
  logic band_done;
  logic wave_ac;

  // Level placed on a pin in shutdown; code 00 waits out the dead-band first
  function automatic logic [1:0] sd_drive(input logic [1:0] code, input logic inv,
                                          input logic prev, input logic prev_oe,
                                          input logic band_done);
    logic [1:0] r;
    r = {prev_oe, prev};
    case (code)
      DRV_HIGH: r = 2'b11;
      DRV_LOW: r = 2'b10;
      DRV_FLOAT: r = 2'b00;
      DRV_INACTIVE: r = band_done ? {1'b1, inv} : {prev_oe, prev};
      default: r = 2'b00;
    endcase
    return r;
  endfunction

  // True in the two steering modes, 000 and 001
  function automatic logic is_steer_mode(input logic [MODE_W-1:0] m);
    return (m == MODE_STEER_ASYNC) || (m == MODE_STEER_SYNC);
  endfunction

  assign wr_sd = reg_write && (reg_addr == OFS_SD_CTRL);
  assign steering_mode = is_steer_mode(gen_mode);
  assign data_rise = data_in && !data_prev;

  // Async steering follows the register at once; only sync steering waits for a data rise
  assign steer_sel = (gen_mode == MODE_STEER_SYNC) ? steer_live : steer_enable;

  // A zero count skips the delay stage and its flop, so A/C keep step with B/D
  assign wave_ac = (rise_deadband_value == '0) ? data_in : wave_delayed;

  // The wait counter is only loaded on leaving RUN, so a zero there means nothing before
  assign band_done = (state != ST_RUN) && (sd_wait == '0);

  // Any enabled source that is asserted requests shutdown
  assign src_active = |(shutdown_src_enable & {shutdown_cell4, shutdown_cell2,
                                               shutdown_comp2, shutdown_comp1,
                                               shutdown_pin_input});

  // Rising dead-band on the data waveform
  wsd_rise_delay #(
    .CNT_W(DB_W)
  ) u_rise (
    .clk(clk),
    .rstn(rstn),
    .din(data_in),
    .count(rise_deadband_value),
    .dout(wave_delayed)
  );

  // Data input history for edge detection
  always_ff @(posedge clk) begin
    if (!rstn) begin
      data_prev <= 1'b0;
    end else begin
      data_prev <= data_in;
    end
  end

  // Steering and override register
  always_ff @(posedge clk) begin
    if (!rstn) begin
      steer_enable <= RST_STEER[STEER_EN_LSB +: NUM_OUT];
      override_level <= RST_STEER[STEER_OVR_LSB +: NUM_OUT];
    end else if (reg_write && (reg_addr == OFS_STEER)) begin
      steer_enable <= reg_wdata[STEER_EN_LSB +: NUM_OUT];
      override_level <= reg_wdata[STEER_OVR_LSB +: NUM_OUT];
    end
  end

  // Shutdown control fields other than the status bit
  always_ff @(posedge clk) begin
    if (!rstn) begin
      restart_enable <= RST_SD_CTRL[SD_RESTART_BIT];
      shutdown_drive_pair_bd <= RST_SD_CTRL[SD_BD_LSB +: 2];
      shutdown_drive_pair_ac <= RST_SD_CTRL[SD_AC_LSB +: 2];
    end else if (wr_sd) begin
      restart_enable <= reg_wdata[SD_RESTART_BIT];
      shutdown_drive_pair_bd <= reg_wdata[SD_BD_LSB +: 2];
      shutdown_drive_pair_ac <= reg_wdata[SD_AC_LSB +: 2];
    end
  end

  // Shutdown status: hardware set wins over any clear
  always_ff @(posedge clk) begin
    if (!rstn) begin
      shutdown_status <= RST_SD_CTRL[SD_STATUS_BIT];
    end else if (src_active) begin
      shutdown_status <= 1'b1;
    end else if (wr_sd) begin
      shutdown_status <= reg_wdata[SD_STATUS_BIT];
    end else if (restart_enable) begin
      shutdown_status <= 1'b0;
    end
  end

  // Shutdown source enables
  always_ff @(posedge clk) begin
    if (!rstn) begin
      shutdown_src_enable <= RST_SRC_EN[SRC_W-1:0];
    end else if (reg_write && (reg_addr == OFS_SRC_EN)) begin
      shutdown_src_enable <= reg_wdata[SRC_W-1:0];
    end
  end

  // Rising dead-band count, taken by the delay stage at each data rise
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rise_deadband_value <= RST_RISE_DB[DB_W-1:0];
    end else if (reg_write && (reg_addr == OFS_RISE_DB)) begin
      rise_deadband_value <= reg_wdata[DB_W-1:0];
    end
  end

  // Generator enable and mode, standing in for the control kept outside this block
  always_ff @(posedge clk) begin
    if (!rstn) begin
      gen_enable <= RST_GEN_CTRL[GEN_ENABLE_BIT];
      gen_mode <= RST_GEN_CTRL[GEN_MODE_LSB +: MODE_W];
    end else if (reg_write && (reg_addr == OFS_GEN_CTRL)) begin
      gen_enable <= reg_wdata[GEN_ENABLE_BIT];
      gen_mode <= reg_wdata[GEN_MODE_LSB +: MODE_W];
    end
  end

  // Output polarity
  always_ff @(posedge clk) begin
    if (!rstn) begin
      invert_out <= RST_POLARITY[NUM_OUT-1:0];
    end else if (reg_write && (reg_addr == OFS_POLARITY)) begin
      invert_out <= reg_wdata[NUM_OUT-1:0];
    end
  end

  // Synchronous steering takes new enables only on a data rising edge
  always_ff @(posedge clk) begin
    if (!rstn) begin
      steer_live <= RST_STEER[STEER_EN_LSB +: NUM_OUT];
    end else if (gen_mode != MODE_STEER_SYNC || data_rise) begin
      steer_live <= steer_enable;
    end
  end

  // Shutdown sequencing
  always_comb begin
    next_state = state;
    case (state)
      ST_RUN: begin
        if (shutdown_status) begin
          next_state = ST_SHUT;
        end
      end
      ST_SHUT: begin
        if (!shutdown_status) begin
          next_state = ST_WAIT_RISE;
        end
      end
      ST_WAIT_RISE: begin
        if (shutdown_status) begin
          next_state = ST_SHUT;
        end else if (data_rise) begin
          next_state = ST_RUN;
        end
      end
      default: next_state = ST_SHUT;
    endcase
  end

  // State register
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state <= ST_RUN;
    end else begin
      state <= next_state;
    end
  end

  // Dead-band wait before the inactive level is placed in shutdown
  always_ff @(posedge clk) begin
    if (!rstn) begin
      sd_wait <= '0;
    end else if (state == ST_RUN && shutdown_status) begin
      sd_wait <= rise_deadband_value;
    end else if (sd_wait != '0) begin
      sd_wait <= sd_wait - 1'b1;
    end
  end

  // Output selection per channel; A and C form one pair, B and D the other
  always_comb begin
    logic [1:0] code;
    logic [1:0] sd;
    logic wave;
    code = 2'h0;
    sd = 2'h0;
    wave = 1'b0;
    next_out = out_q;
    next_oe = oe_q;
    for (int i = 0; i < NUM_OUT; i++) begin
      code = i[0] ? shutdown_drive_pair_bd : shutdown_drive_pair_ac;
      // Bridge modes: A/C take the delayed rise, B/D the complement
      wave = i[0] ? !data_in : wave_ac;
      if (state != ST_RUN || shutdown_status) begin
        sd = sd_drive(code, invert_out[i], out_q[i], oe_q[i], band_done);
        next_out[i] = sd[0];
        next_oe[i] = sd[1];
      end else if (!gen_enable) begin
        // Disabled: park at the inactive level
        next_out[i] = invert_out[i];
        next_oe[i] = 1'b1;
      end else if (steering_mode) begin
        next_oe[i] = 1'b1;
        if (steer_sel[i]) begin
          next_out[i] = data_in ^ invert_out[i];
        end else begin
          next_out[i] = override_level[i];
        end
      end else begin
        next_oe[i] = 1'b1;
        next_out[i] = wave ^ invert_out[i];
      end
    end
  end

  // Output pins are registered so they never glitch on select changes
  always_ff @(posedge clk) begin
    if (!rstn) begin
      out_q <= '0;
      oe_q <= '0;
    end else begin
      out_q <= next_out;
      oe_q <= next_oe;
    end
  end

  assign wave_out_a = out_q[0];
  assign wave_out_b = out_q[1];
  assign wave_out_c = out_q[2];
  assign wave_out_d = out_q[3];
  assign wave_oe_a = oe_q[0];
  assign wave_oe_b = oe_q[1];
  assign wave_oe_c = oe_q[2];
  assign wave_oe_d = oe_q[3];

  // Read data stand only in the cycle after the read strobe
  always_ff @(posedge clk) begin
    if (!rstn) begin
      reg_rdata <= '0;
    end else if (reg_read) begin
      case (reg_addr)
        OFS_STEER: reg_rdata <= {override_level, steer_enable};
        OFS_SD_CTRL: reg_rdata <= {shutdown_status, restart_enable, shutdown_drive_pair_bd,
                                   shutdown_drive_pair_ac, 2'h0};
        OFS_SRC_EN: reg_rdata <= {3'h0, shutdown_src_enable};
        OFS_RISE_DB: reg_rdata <= {2'h0, rise_deadband_value};
        OFS_GEN_CTRL: reg_rdata <= {gen_enable, 4'h0, gen_mode};
        OFS_POLARITY: reg_rdata <= {4'h0, invert_out};
        default: reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

endmodule

// >>> wsd_power_stage.sv
// Behavioural power stage fed by the four output pins
`timescale 1ns/10ps
module wsd_power_stage (
  input wire logic clk,
  input wire logic [3:0] drv,
  input wire logic [3:0] oe,
  output logic [3:0] pin
);
  logic flip = 1'b0;
  // A released pin has no keeper, so it shows a level that changes every cycle
  always @(posedge clk) begin
    flip <= ~flip;
  end
  assign pin = (drv & oe) | ({4{flip}} & ~oe);
endmodule

// >>> wsd_props.sv
// Assertion checker for the waveform steer/shutdown block
`timescale 1ns/10ps
module wsd_props
  import wsd_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic data_in,
  input wire logic shutdown_pin_input,
  input wire logic shutdown_comp1,
  input wire logic shutdown_comp2,
  input wire logic shutdown_cell2,
  input wire logic shutdown_cell4,
  input wire logic wave_out_a,
  input wire logic wave_out_b,
  input wire logic wave_out_c,
  input wire logic wave_out_d,
  input wire logic wave_oe_a,
  input wire logic wave_oe_b,
  input wire logic wave_oe_c,
  input wire logic wave_oe_d
);
  logic [7:0] sh [0:7];
  logic clean;
  logic hit;
  logic run0;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // Shadow of software writes; status is not mirrored since hardware moves it
  always_ff @(posedge clk) begin
    if (!rstn) begin
      sh <= '{default: 8'h00};
      sh[1] <= RST_SD_CTRL;
    end else if (reg_write) begin
      sh[reg_addr] <= reg_wdata;
    end
  end
  // Clean means the status bit cannot have been set since reset
  always_ff @(posedge clk) begin
    if (!rstn) begin
      clean <= 1'b1;
    end else if (hit || (reg_write && reg_addr == OFS_SD_CTRL && reg_wdata[7])) begin
      clean <= 1'b0;
    end
  end
  // Enabled source asserted, and plain asynchronous steering
  assign hit = |(sh[2][4:0] & {shutdown_cell4, shutdown_cell2, shutdown_comp2,
    shutdown_comp1, shutdown_pin_input});
  assign run0 = clean && sh[4][7] && sh[4][2:0] == 3'h0;
  sequence s_hit(logic [3:0] code);
    hit && !reg_write && sh[1][5:2] == code ##1 !reg_write;
  endsequence
  property p_rd_idle;
    !reg_read |=> reg_rdata == 8'h00;
  endproperty
  property p_unused;
    reg_read |=> ($past(reg_addr) != OFS_SD_CTRL || reg_rdata[1:0] == 2'h0) &&
      ($past(reg_addr) != OFS_SRC_EN || reg_rdata[7:5] == 3'h0) &&
      ($past(reg_addr) != OFS_RISE_DB || reg_rdata[7:6] == 2'h0);
  endproperty
  property p_status;
    hit ##1 (reg_read && reg_addr == OFS_SD_CTRL) |=> reg_rdata[7];
  endproperty
  property p_sd_drive;
    s_hit(4'hE) |=> {wave_oe_d, wave_oe_c, wave_oe_b, wave_oe_a,
      wave_out_d, wave_out_c, wave_out_b, wave_out_a} == 8'hFA;
  endproperty
  property p_sd_float;
    s_hit(4'h5) |=> {wave_oe_d, wave_oe_c, wave_oe_b, wave_oe_a} == 4'h0;
  endproperty
  property p_steer;
    run0 && sh[0][0] |=> wave_out_a == ($past(data_in) ^ $past(sh[5][0]));
  endproperty
  property p_ovr;
    run0 && !sh[0][1] |=> wave_out_b == $past(sh[0][5]);
  endproperty
  property p_ignore;
    clean && sh[4][7] && sh[4][2:1] != 2'h0 |=> wave_out_b == (!$past(data_in) ^ $past(sh[5][1]));
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero when idle");
  a_unused: assert property (p_unused) else $error("unused bit read as one");
  a_status: assert property (p_status) else $error("status clear with source on");
  a_sd_drive: assert property (p_sd_drive) else $error("wrong shutdown drive");
  a_sd_float: assert property (p_sd_float) else $error("pins not released");
  a_steer: assert property (p_steer) else $error("steered output wrong");
  a_ovr: assert property (p_ovr) else $error("override level wrong");
  a_ignore: assert property (p_ignore) else $error("steering bits not ignored");
endmodule
bind wsd_top wsd_props u_wsd_props (.*);

// >>> wsd_top_tb_top.sv
// Self-checking testbench of the waveform steer/shutdown block
`timescale 1ns/10ps
module wsd_top_tb_top import wsd_pkg::*;;
  logic clk = 1'b0;
  logic rstn, reg_write, reg_read, data_in;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata;
  logic shutdown_pin_input, shutdown_comp1, shutdown_comp2, shutdown_cell2, shutdown_cell4;
  logic wave_out_a, wave_out_b, wave_out_c, wave_out_d;
  logic wave_oe_a, wave_oe_b, wave_oe_c, wave_oe_d;
  logic [4:0] src;
  logic [3:0] pin, oe;
  logic [7:0] st, pol, v;
  int n_fail = 0;
  int samples_checked = 0;
  int dn;
  always #25 clk = ~clk;
  assign {shutdown_cell4, shutdown_cell2, shutdown_comp2, shutdown_comp1, shutdown_pin_input} = src;
  assign oe = {wave_oe_d, wave_oe_c, wave_oe_b, wave_oe_a};
  wsd_top u_wsd_top (.*);
  wsd_power_stage u_wsd_power_stage (.clk(clk), .drv({wave_out_d, wave_out_c, wave_out_b,
    wave_out_a}), .oe(oe), .pin(pin));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask
  // Read data stand only in the cycle after the read edge
  task automatic rdc(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  task automatic rst;
    @(posedge clk);
    rstn <= 1'b0;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
  endtask
  task automatic tally_and_finish;
    if (n_fail == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Pin levels for a mode and data level; non-steering modes give A/C the data and B/D its complement
  function automatic logic [3:0] exp_out(input logic [2:0] m, input logic d);
    for (int x = 0; x < 4; x++) begin
      exp_out[x] = (m[2:1] == 2'h0) ? (st[x] ? d ^ pol[x] : st[4+x]) : (x[0] ? ~d : d) ^ pol[x];
    end
  endfunction
  // Watchdog well beyond the expected run length
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    tally_and_finish();
  end
  initial begin
    rstn = 1'b0;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    reg_write = 1'b0;
    reg_read = 1'b0;
    data_in = 1'b0;
    src = 5'h00;
    void'($urandom(76790));
    rst();
    // Shutdown control reset value, then read-back of all-ones writes (0xBF at place 1) to all places but 4 and 5, unmapped places included
    rdc(OFS_SD_CTRL, 8'h14);
    for (int i = 0; i < 8; i++) begin
      v = (i == 1) ? 8'hBC : (i == 0) ? 8'hFF : (i == 2) ? 8'h1F : (i == 3) ? 8'h3F : 8'h00;
      if (i != 4 && i != 5) begin
        wr(3'(i), (i == 1) ? 8'hBF : 8'hFF);
        rdc(3'(i), v);
      end
    end
    chk({oe, pin}, 8'hFF);
    // Cleared status keeps the shutdown drive until data rises
    wr(OFS_SD_CTRL, 8'hA8);
    wr(OFS_STEER, 8'h0F);
    wr(OFS_POLARITY, 8'h00);
    wr(OFS_GEN_CTRL, 8'h80);
    @(posedge clk) data_in <= 1'b1;
    wr(OFS_SD_CTRL, 8'h28);
    repeat (4) @(posedge clk);
    #1 chk({oe, pin}, 8'hF0);
    @(posedge clk) data_in <= 1'b0;
    @(posedge clk) data_in <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk({oe, pin}, 8'hFF);
    // Steering and plain modes with random settings and data
    rst();
    for (int m = 0; m < 6; m++) begin
      // Mode 0 always has A steered and B overridden, so both cases are seen
      st = (m == 0) ? ((8'($urandom) & 8'hFC) | 8'h01) : 8'($urandom);
      pol = 8'($urandom) & 8'h0F;
      wr(OFS_STEER, st);
      wr(OFS_POLARITY, pol);
      wr(OFS_GEN_CTRL, 8'h80 | 8'(m));
      @(posedge clk) data_in <= 1'b0;
      @(posedge clk) data_in <= 1'b1;
      repeat (20) begin
        @(posedge clk) data_in <= 1'($urandom);
        @(posedge clk) #1 chk({oe, pin}, {4'hF, exp_out(3'(m), data_in)});
      end
    end
    // Rising dead-band length measured from the data edge
    wr(OFS_POLARITY, 8'h00);
    wr(OFS_GEN_CTRL, 8'h84);
    for (int k = 0; k < 4; k++) begin
      v = (k == 0) ? 8'h00 : (k == 1) ? 8'h01 : (k == 2) ? 8'h3F : 8'($urandom_range(62, 2));
      wr(OFS_RISE_DB, v);
      @(posedge clk) data_in <= 1'b0;
      repeat (70) @(posedge clk);
      data_in <= 1'b1;
      dn = 0;
      do begin
        @(posedge clk) #1 dn++;
      end while (wave_out_a !== 1'b1 && dn < 100);
      chk({7'h0, v == 0 ? dn == 1 : (dn - 1 - v) inside {0, 1}}, 8'h01);
    end
    // Each shutdown source alone, with and without auto-restart
    rst();
    wr(OFS_GEN_CTRL, 8'h80);
    for (int i = 0; i < 5; i++) begin
      v = i[0] ? 8'h78 : 8'h14;
      wr(OFS_SD_CTRL, v);
      wr(OFS_SRC_EN, 8'(1 << i));
      @(posedge clk) src <= ~(5'h01 << i);
      repeat (3) @(posedge clk);
      rdc(OFS_SD_CTRL, v);
      @(posedge clk) src <= 5'h1F;
      repeat (3) @(posedge clk);
      #1 chk({oe, i[0] ? pin : 4'h0}, i[0] ? 8'hFA : 8'h00);
      wr(OFS_SD_CTRL, v);
      rdc(OFS_SD_CTRL, v | 8'h80);
      @(posedge clk) src <= 5'h00;
      repeat (4) @(posedge clk);
      rdc(OFS_SD_CTRL, i[0] ? v : v | 8'h80);
    end
    // Code 00: last level held through the dead-band, then inactive level with polarity
    wr(OFS_STEER, 8'hF0);
    wr(OFS_POLARITY, 8'h05);
    wr(OFS_RISE_DB, 8'h04);
    wr(OFS_SD_CTRL, 8'h40);
    @(posedge clk) data_in <= 1'b0;
    @(posedge clk) data_in <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk({oe, pin}, 8'hFF);
    @(posedge clk) src <= 5'h1F;
    repeat (3) @(posedge clk);
    #1 chk({oe, pin}, 8'hFF);
    repeat (5) @(posedge clk);
    #1 chk({oe, pin}, 8'hF5);
    tally_and_finish();
  end
endmodule
